// file: acb_dev_model.sv
// Behavioural model of the bus-interfaced converter for the host test.
// Assumes the bench resolves the open-drain ready line with a pull-up.
`timescale 1ns/10ps
module acb_dev_model (
    input wire logic sel_n_i,          // Device select, active low
    input wire logic wr_n_i,           // Conversion start strobe
    input wire logic rd_n_i,           // Read strobe
    input wire logic mode_i,           // 1 write-then-read
    input wire logic chan_i,           // Channel pin
    input wire logic [7:0] code_i,     // Code seen on channel 1
    input wire logic ovr_i,            // Input above range
    input wire logic mute_i,           // Never finish converting
    input int conv_ns_i,               // Conversion time in ns
    output logic [7:0] result_bus_o,   // Result byte
    output logic done_n_o,             // Completion flag
    output logic rdy_oe_o,             // Ready pulled low when high
    output logic overrange_flag_n_o    // Over-range flag
);
    logic [7:0] latch_q = 8'h00;
    initial done_n_o = 1'b1;
    initial rdy_oe_o = 1'b0;
    initial overrange_flag_n_o = 1'b1;

    // A muted device never finishes, to provoke the host's timeout
    task automatic convert();
        #(conv_ns_i);
        if (!mute_i) begin
            latch_q = ovr_i ? 8'hff : (chan_i ? code_i : ~code_i);
            overrange_flag_n_o = !ovr_i;
            done_n_o = 1'b0;
            rdy_oe_o = 1'b0;
        end
    endtask : convert

    // Strobes count only while selected
    always @(negedge wr_n_i) if (!sel_n_i && mode_i) convert();
    // Select and read fall on one edge here; settle before deciding
    always @(negedge rd_n_i or negedge sel_n_i) begin
        #1;
        if (!sel_n_i && !rd_n_i && !mode_i) convert();
    end
    always @(negedge sel_n_i) begin
        #1;
        if (!mode_i) rdy_oe_o = 1'b1;
    end
    always @(posedge sel_n_i) rdy_oe_o = 1'b0;
    always @(posedge rd_n_i) if (!sel_n_i) done_n_o = 1'b1;
    // Floating bus shows the inverse, never a stale match
    assign result_bus_o = (!sel_n_i && !rd_n_i) ? latch_q : ~latch_q;
endmodule : acb_dev_model

// file: acb_host.sv
// Host controller driving an 8-bit bus-interfaced converter.
// Assumes the device pins are asynchronous and the ready line has an
// external pull-up on the board.
// Operation
// [RULE1] Write mode: conversion starts on write fall
// [RULE2] Result latched at end of conversion
// [RULE3] Host holds mode high for write mode
// [RULE4] Mode low or floating selects read-only
// [RULE5] Ready is open drain, needs pull-up
// [RULE6] Ready low after select, high when done
// [RULE7] Read-only: hold read low until data
// [RULE8] Write mode: write strobe, then read
// [RULE9] Result driven only while read low
// [RULE10] Read-only: conversion starts on read fall
// [RULE11] Completion flag low when result latched
// [RULE12] Read rising edge clears completion flag
// [RULE13] Eight result bits, bit 0 least
// [RULE14] Write mode conversion within 560 ns
// [RULE15] Strobes ignored while select is high
// [RULE16] Channel select 0 first, 1 second
// [RULE17] Overrange low forces all bits high
// [RULE18] Wait for completion flag before reading
`timescale 1ns/10ps
module acb_host
    import acb_pkg::*;
#(
    parameter int TIMEOUT_CYC = acb_pkg::ACB_TIMEOUT_CYC
) (
    input wire logic core_clk_i,            // 100 MHz clock
    input wire logic sys_rst_i,             // Async reset, high
    input wire logic start_i,               // Pulse: start conversion
    input wire logic wr_mode_i,             // 1 write-then-read mode
    input wire logic chan_i,                // Channel to convert
    output logic busy_o,                    // Transfer in progress
    output logic valid_o,                   // Pulse: result ready
    output logic [acb_pkg::ACB_DATA_W-1:0] result_o, // Result code
    output logic overrange_o,               // Result was over range
    output logic timeout_o,                 // Pulse: device silent
    output logic mode_sel_o,                // Device mode pin
    output logic sel_n_o,                   // Device select
    output logic wr_n_o,                    // Conversion start strobe
    output logic rd_n_o,                    // Read strobe
    output logic channel_select_o,          // Channel select pin
    input wire logic [7:0] result_bus_i,    // Device result bus
    input wire logic done_n_i,              // Completion flag
    input wire logic rdy_i,                 // Ready line, pulled up
    input wire logic overrange_flag_n_i     // Overrange flag
);
    import acb_pkg::*;

    acb_sync_if sif ();
    logic [10:0] raw_pins, sync_pins;

    // All device outputs pass the three-stage filter
    assign raw_pins = {overrange_flag_n_i, rdy_i, done_n_i, result_bus_i};

    acb_sync #(.W(11)) u_sync (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(raw_pins),
        .val_o(sync_pins)
    );

    assign sif.data = sync_pins[7:0];
    assign sif.done_n = sync_pins[8];
    assign sif.rdy = sync_pins[9];
    assign sif.ovr_n = sync_pins[10];

    acb_state_t state_q, state_d;
    logic [ACB_CNT_W-1:0] cnt_q, cnt_d;
    logic wr_mode_q, wr_mode_d;
    logic sel_n_q, sel_n_d, wr_n_q, wr_n_d, rd_n_q, rd_n_d;
    logic chan_q, chan_d, busy_q, busy_d, valid_q, valid_d;
    logic tout_q, tout_d, ovr_q, ovr_d;
    logic [7:0] res_q, res_d;
    logic seen_q, seen_d;

    // Sequencer: drives strobes and collects the result
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        wr_mode_d = wr_mode_q;
        sel_n_d = sel_n_q;
        wr_n_d = wr_n_q;
        rd_n_d = rd_n_q;
        chan_d = chan_q;
        busy_d = busy_q;
        valid_d = 1'b0;
        tout_d = 1'b0;
        ovr_d = ovr_q;
        res_d = res_q;
        seen_d = seen_q;
        case (state_q)
            ACB_IDLE: begin
                if (start_i) begin
                    // Mode and channel set on the same clock edge that select falls
                    wr_mode_d = wr_mode_i; // RULE3 RULE4
                    chan_d = chan_i; // RULE16
                    sel_n_d = 1'b0; // RULE15
                    busy_d = 1'b1;
                    cnt_d = '0;
                    seen_d = 1'b0;
                    state_d = wr_mode_i ? ACB_WSTRB : ACB_READ;
                    if (!wr_mode_i) begin
                        rd_n_d = 1'b0; // RULE10 RULE7
                    end
                end
            end
            ACB_WSTRB: begin
                // Falling edge of write starts the conversion
                wr_n_d = 1'b0; // RULE1 RULE8
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == ACB_CNT_W'(ACB_STROBE_CYC)) begin
                    wr_n_d = 1'b1;
                    cnt_d = '0;
                    state_d = ACB_WAIT;
                end
            end
            ACB_WAIT: begin
                // Completion flag marks the latched result
                cnt_d = cnt_q + 1'b1;
                if (!sif.done_n) begin // RULE11 RULE18 RULE2
                    rd_n_d = 1'b0; // RULE8 RULE9
                    cnt_d = '0;
                    state_d = ACB_READ;
                end else if (cnt_q == ACB_CNT_W'(TIMEOUT_CYC)) begin
                    // Device exceeded 560 ns by far; give up
                    tout_d = 1'b1; // RULE14
                    state_d = ACB_DONE;
                end
            end
            ACB_READ: begin
                cnt_d = cnt_q + 1'b1;
                if (wr_mode_q) begin
                    // Bus driven only while read is low
                    if (cnt_q == ACB_CNT_W'(ACB_READ_CYC)) begin
                        state_d = ACB_RDONE; // RULE9
                    end
                end else begin
                    // Ready low first, release means data present
                    if (!sif.rdy) begin
                        seen_d = 1'b1; // RULE6 RULE5
                    end
                    if (seen_q && sif.rdy) begin
                        cnt_d = '0;
                        state_d = ACB_RDONE; // RULE7
                    end else if (cnt_q == ACB_CNT_W'(TIMEOUT_CYC)) begin
                        tout_d = 1'b1;
                        state_d = ACB_DONE;
                    end
                end
            end
            ACB_RDONE: begin
                // Capture, then raise read to clear the flag
                res_d = sif.data; // RULE13
                ovr_d = ~sif.ovr_n; // RULE17
                valid_d = 1'b1;
                rd_n_d = 1'b1; // RULE12
                state_d = ACB_DONE;
            end
            ACB_DONE: begin
                rd_n_d = 1'b1;
                wr_n_d = 1'b1;
                sel_n_d = 1'b1;
                busy_d = 1'b0;
                state_d = ACB_IDLE;
            end
            default: begin
                state_d = ACB_IDLE;
            end
        endcase
    end

    // Registers; strobes idle high so the device sees no edge
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ACB_IDLE;
            cnt_q <= '0;
            wr_mode_q <= 1'b0;
            sel_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            chan_q <= 1'b0;
            busy_q <= 1'b0;
            valid_q <= 1'b0;
            tout_q <= 1'b0;
            ovr_q <= 1'b0;
            res_q <= ACB_RESULT_RST;
            seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wr_mode_q <= wr_mode_d;
            sel_n_q <= sel_n_d;
            wr_n_q <= wr_n_d;
            rd_n_q <= rd_n_d;
            chan_q <= chan_d;
            busy_q <= busy_d;
            valid_q <= valid_d;
            tout_q <= tout_d;
            ovr_q <= ovr_d;
            res_q <= res_d;
            seen_q <= seen_d;
        end
    end

    assign busy_o = busy_q;
    assign valid_o = valid_q;
    assign result_o = res_q;
    assign overrange_o = ovr_q;
    assign timeout_o = tout_q;
    assign mode_sel_o = wr_mode_q; // RULE3
    assign sel_n_o = sel_n_q;
    assign wr_n_o = wr_n_q;
    assign rd_n_o = rd_n_q;
    assign channel_select_o = chan_q;
endmodule : acb_host

// file: acb_host_chk.sv
// Checker on the host controller's device-side and user-side ports.
// Assumes one clock domain; bound to every host instance.
`timescale 1ns/10ps
module acb_host_chk (
    input wire logic core_clk_i,       // Clock
    input wire logic sys_rst_i,        // Reset
    input wire logic start_i,          // Start request
    input wire logic busy_o,           // Busy
    input wire logic valid_o,          // Result pulse
    input wire logic [7:0] result_o,   // Result
    input wire logic overrange_o,      // Over range
    input wire logic mode_sel_o,       // Mode pin
    input wire logic sel_n_o,          // Select
    input wire logic wr_n_o,           // Start strobe
    input wire logic rd_n_o,           // Read strobe
    input wire logic done_n_i,         // Completion flag
    input wire logic rdy_i             // Ready line
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_start_taken: assert property (start_i && !busy_o |=> busy_o && !sel_n_o)
        else $error("start request not taken");
    chk_strobe_select: assert property (!wr_n_o || !rd_n_o |-> !sel_n_o)
        else $error("strobe without select");
    chk_wr_width: assert property ($fell(wr_n_o) |-> !wr_n_o [*4] ##1 wr_n_o)
        else $error("start strobe width wrong");
    chk_wr_alone: assert property (!wr_n_o |-> rd_n_o && mode_sel_o)
        else $error("start strobe overlaps read");
    chk_mode_steady: assert property (!sel_n_o && !$past(sel_n_o) |-> $stable(mode_sel_o))
        else $error("mode pin moved while selected");
    chk_read_after_done: assert property ($fell(rd_n_o) && mode_sel_o |-> !$past(done_n_i, 2))
        else $error("read before completion flag");
    chk_hold_read: assert property (!rd_n_o && !mode_sel_o && !rdy_i |=> !rd_n_o)
        else $error("read released during conversion");
    chk_valid_after_read: assert property (valid_o |-> rd_n_o && $past(!rd_n_o))
        else $error("result without read strobe");
    chk_ovr_all_ones: assert property (valid_o && overrange_o |-> result_o == 8'hff)
        else $error("over-range result not all ones");
    cov_wr_read: cover property (valid_o && mode_sel_o);
    cov_rd_read: cover property (valid_o && !mode_sel_o);
    cov_overrange: cover property (valid_o && overrange_o);
endmodule : acb_host_chk
bind acb_host acb_host_chk u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .start_i(start_i), .busy_o(busy_o), .valid_o(valid_o), .result_o(result_o),
    .overrange_o(overrange_o), .mode_sel_o(mode_sel_o), .sel_n_o(sel_n_o),
    .wr_n_o(wr_n_o), .rd_n_o(rd_n_o), .done_n_i(done_n_i), .rdy_i(rdy_i));

// file: acb_pkg.sv
// Package for the converter bus host controller.
// Assumes a 100 MHz core clock; holds timing counts and state codes.
package acb_pkg;
    localparam int ACB_CLK_MHZ = 100;
    localparam int ACB_CLK_PERIOD_NS = 10;
    // Longest conversion time, write-then-read mode
    localparam int ACB_CONV_MAX_NS = 560;
    // Wait covers the longest conversion, so round up
    localparam int ACB_CONV_CYC =
        (ACB_CONV_MAX_NS + ACB_CLK_PERIOD_NS - 1) / ACB_CLK_PERIOD_NS;
    // Strobe width and setup, in cycles
    localparam int ACB_STROBE_CYC = 4;
    localparam int ACB_READ_CYC = 4;
    // Timeout on waiting for the device, in cycles
    localparam int ACB_TIMEOUT_CYC = 200;
    localparam int ACB_CNT_W = 8;
    localparam int ACB_DATA_W = 8;
    localparam logic [7:0] ACB_RESULT_RST = 8'h00;

    typedef enum logic [5:0] {
        ACB_IDLE  = 6'b00_0001,
        ACB_WSTRB = 6'b00_0010,
        ACB_WAIT  = 6'b00_0100,
        ACB_READ  = 6'b00_1000,
        ACB_RDONE = 6'b01_0000,
        ACB_DONE  = 6'b10_0000
    } acb_state_t;
endpackage : acb_pkg

// file: acb_sync.sv
// Three-stage synchroniser for the device pins.
// Assumes pins are asynchronous to core_clk_i; a change counts when
// the second and third stages agree.
`timescale 1ns/10ps
module acb_sync #(
    parameter int W = 11
) (
    input wire logic core_clk_i,  // Core clock
    input wire logic sys_rst_i,   // Async reset, active high
    input wire logic [W-1:0] pin_i, // Raw pin levels
    output logic [W-1:0] val_o    // Filtered levels
);
    logic [W-1:0] s1_q, s2_q, s3_q, val_q;
    logic [W-1:0] val_d;

    // Accept a bit only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            val_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : val_q[i];
        end
    end

    // Pins idle high (ready, flags), hence all-ones reset
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            val_q <= '1;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            val_q <= val_d;
        end
    end

    assign val_o = val_q;
endmodule : acb_sync

// file: acb_sync_if.sv
// Interface carrying the synchronised device pins to the main FSM.
// Assumes one clock domain; the synchroniser drives, the FSM reads.
`timescale 1ns/10ps
interface acb_sync_if;
    logic done_n;
    logic rdy;
    logic ovr_n;
    logic [7:0] data;
    modport src (output done_n, output rdy, output ovr_n, output data);
    modport dst (input done_n, input rdy, input ovr_n, input data);
endinterface : acb_sync_if

// file: adc_bus_conversion_interface_test.sv
// Self-checking bench for the converter host controller.
// Assumes the device model answers within the host's timeout unless muted.
`timescale 1ns/10ps
module adc_bus_conversion_interface_test;
    logic clk, rst, start, wr_mode, chan, busy, valid, ovr, tmo;
    logic mode_sel, sel_n, wr_n, rd_n, chsel, done_n, rdy_oe, ovr_n;
    logic ovr_in, mute, rdy;
    logic [7:0] result, rbus, code;
    logic [9:0] notes_q[$];
    int conv_ns, num_errors = 0, n_checks = 0, cyc = 0, i;

    acb_host #(.TIMEOUT_CYC(100)) dut (.core_clk_i(clk), .sys_rst_i(rst),
        .start_i(start), .wr_mode_i(wr_mode), .chan_i(chan), .busy_o(busy),
        .valid_o(valid), .result_o(result), .overrange_o(ovr),
        .timeout_o(tmo), .mode_sel_o(mode_sel), .sel_n_o(sel_n),
        .wr_n_o(wr_n), .rd_n_o(rd_n), .channel_select_o(chsel),
        .result_bus_i(rbus), .done_n_i(done_n), .rdy_i(rdy),
        .overrange_flag_n_i(ovr_n));
    acb_dev_model u_dev (.sel_n_i(sel_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
        .mode_i(mode_sel), .chan_i(chsel), .code_i(code), .ovr_i(ovr_in),
        .mute_i(mute), .conv_ns_i(conv_ns), .result_bus_o(rbus),
        .done_n_o(done_n), .rdy_oe_o(rdy_oe), .overrange_flag_n_o(ovr_n));
    assign rdy = rdy_oe ? 1'b0 : 1'b1;

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [9:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // One conversion; a second start while busy must be ignored
    task automatic conv(input logic m, c, input logic [7:0] d,
                        input logic o, u, input int ns);
        @(negedge clk);
        {wr_mode, chan, ovr_in, mute} = {m, c, o, u};
        code = d;
        conv_ns = ns;
        notes_q.push_back(u ? 10'h200 : {1'b0, o, o ? 8'hff : (c ? d : ~d)});
        start = 1'b1;
        @(negedge clk);
        check("mode pin", 10'(mode_sel), 10'(m));
        check("channel pin", 10'(chsel), 10'(c));
        @(negedge clk);
        start = 1'b0;
        while (busy) @(negedge clk);
        check("flag cleared", 10'(done_n), 10'h001);
        $display("test done mode %0d chan %0d ovr %0d mute %0d", m, c, o, u);
    endtask : conv

    // Results are compared in their one valid cycle
    always @(negedge clk) begin
        if (valid || tmo) begin
            if (notes_q.size() == 0) check("extra result", 10'h3ff, 10'h000);
            else check("result", tmo ? 10'h200 : {1'b0, ovr, result},
                       notes_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish;
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        start = 1'b0;
        {wr_mode, chan, ovr_in, mute} = 4'h0;
        code = 8'h00;
        conv_ns = 100;
        void'($urandom(32'h1e10));
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        conv(1'b1, 1'b0, 8'h5a, 1'b0, 1'b0, 560);
        conv(1'b0, 1'b1, 8'ha5, 1'b0, 1'b0, 100);
        conv(1'b1, 1'b1, 8'h00, 1'b1, 1'b0, 300);
        conv(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 560);
        conv(1'b1, 1'b0, 8'h3c, 1'b0, 1'b1, 200);
        conv(1'b1, 1'b1, 8'h81, 1'b0, 1'b0, 100);
        for (i = 0; i < 8; i++) begin
            conv(1'($urandom), 1'($urandom), 8'($urandom), 1'b0, 1'b0,
                 100 + int'($urandom % 461));
        end
        repeat (4) @(negedge clk);
        check("pending results", 10'(notes_q.size()), 10'h000);
        tally_and_finish;
    end
endmodule : adc_bus_conversion_interface_test
